// file: sac_pkg.sv
// package: register map, field layout and timing counts of the conversion control
package sac_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CHREF = 8'h08;
  localparam logic [7:0] OFS_RES_LOW = 8'h0c;
  localparam logic [7:0] OFS_RES_HIGH = 8'h10;
  localparam logic [7:0] OFS_MISC = 8'h14;
  // converter_control_status_a fields
  localparam int A_ENABLE = 7;
  localparam int A_START = 6;
  localparam int A_AUTO = 5;
  localparam int A_FLAG = 4;
  localparam int A_PRESC_LO = 0;
  localparam int PRESC_W = 3;
  // converter_control_status_b fields
  localparam int B_TSEL_LO = 0;
  localparam int TSEL_W = 3;
  // channel_reference_select_register fields
  localparam int M_REF_LO = 6;
  localparam int M_ALIGN = 5;
  localparam int M_CH_LO = 0;
  localparam int CH_W = 5;
  // analog_misc_control_register fields
  localparam int X_EXTREF = 0;
  localparam int X_REFOUT = 1;
  localparam int X_INTERNAL_CURRENT_SOURCE = 2;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  // result width
  localparam int RES_W = 10;
  // trigger code for the own completion flag (free running)
  localparam logic [TSEL_W-1:0] TSEL_OWN_FLAG = 3'h0;
  // channel codes of the special channels
  localparam logic [CH_W-1:0] CH_LAST_SINGLE = 5'h0a;
  localparam logic [CH_W-1:0] CH_TEMP = 5'h0b;
  localparam logic [CH_W-1:0] CH_INTERNAL_CURRENT_SOURCE = 5'h0c;
  localparam int CH_DIFF_BIT = 4;
  localparam int CH_GAIN20_BIT = 3;
  // timing in half converter clock cycles
  localparam logic [5:0] HALF_NORMAL_TOTAL = 6'd26;
  localparam logic [5:0] HALF_FIRST_TOTAL = 6'd50;
  localparam logic [5:0] HALF_AUTO_TOTAL = 6'd27;
  localparam logic [5:0] HALF_NORMAL_SH = 6'd3;
  localparam logic [5:0] HALF_FIRST_SH = 6'd27;
  localparam logic [5:0] HALF_AUTO_SH = 6'd4;
  localparam logic [5:0] HALF_LAST_CYCLE = 6'd2;

  typedef enum logic [1:0] {KIND_NORMAL, KIND_FIRST, KIND_AUTO} sac_kind_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} sac_state_e;

  typedef struct packed {
    logic [1:0] reference;
    logic extRef;
    logic [CH_W-1:0] channel;
  } sac_sel_s;

  typedef struct packed {
    logic on;
    logic [1:0] reference;
    logic extRef;
    logic refOut;
    logic isrcOn;
    logic [CH_W-1:0] channel;
    logic gainOn;
    logic gain20;
    logic tempSel;
    logic isrcSel;
  } sac_analog_s;
endpackage

// file: sac_conversion_control.sv
// module: control of a 10-bit successive approximation converter behind an APB slave
// How it works
// [R1] result right aligned, left when align set
// [R2] low read locks results until high read
// [R3] flag still sets when result discarded
// [R4] start bit begins conversion, cleared at completion
// [R5] channel change waits for current conversion end
// [R6] trigger rising edge resets prescaler, starts conversion
// [R7] edges during conversion ignored, no level restart
// [R8] flag trigger needs clear before next event
// [R9] own flag as trigger means free running
// [R10] start bit works under auto, reads busy
// [R11] prescaler runs while enabled, reset otherwise
// [R12] selections applied only while converter enabled; refOut and isrcOn follow misc regardless
// [R13] bit start waits for next converter clock
// [R14] 13 cycles normal, 25 cycles first conversion
// [R15] sample at 1.5, first at 13.5
// [R16] completion writes result, sets flag, clears start
// [R17] auto sample 2 cycles after trigger edge
// [R18] free running restarts immediately, start stays high
// [R19] differential codes use gain stage, else bypass
// [R20] five-bit channel field decodes all input kinds
// [R21] reference field plus external enable select reference
// [R22] selection shadow frozen during conversion until last cycle
// [R23] trigger select indexes event source multiplexer
// [R24] prescaler select picks power-of-two divisions
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module sac_conversion_control (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] triggerSources,
  input wire logic [9:0] coreResult,
  output sac_pkg::sac_analog_s analogSel,
  output logic sampleHold,
  output logic convBusy,
  output logic convDone
);
  logic [7:0] ctrlA;
  logic [7:0] ctrlB;
  logic [7:0] chRef;
  logic [7:0] misc;
  logic flag;
  logic lock;
  logic [9:0] result;
  sac_pkg::sac_state_e state;
  sac_pkg::sac_kind_e kind;
  logic [5:0] halfCount;
  logic [7:0] presc;
  logic firstPending;
  logic enPrev;
  logic trigD1;
  logic trigD2;
  sac_pkg::sac_sel_s shadow;

  // bus decode
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire wrEn = accessDone & pwrite;
  wire rdEn = accessDone & ~pwrite;
  wire hitA = paddr == sac_pkg::OFS_CTRL_A;
  wire hitB = paddr == sac_pkg::OFS_CTRL_B;
  wire hitM = paddr == sac_pkg::OFS_CHREF;
  wire hitL = paddr == sac_pkg::OFS_RES_LOW;
  wire hitH = paddr == sac_pkg::OFS_RES_HIGH;
  wire hitX = paddr == sac_pkg::OFS_MISC;
  wire mapped = hitA | hitB | hitM | hitL | hitH | hitX;
  wire wrA = wrEn & hitA;

  wire enable = ctrlA[sac_pkg::A_ENABLE];
  wire autoOn = ctrlA[sac_pkg::A_AUTO];
  wire [sac_pkg::PRESC_W-1:0] prescSel = ctrlA[sac_pkg::A_PRESC_LO +: sac_pkg::PRESC_W];
  wire [sac_pkg::TSEL_W-1:0] tsel = ctrlB[sac_pkg::B_TSEL_LO +: sac_pkg::TSEL_W];
  wire align = chRef[sac_pkg::M_ALIGN];

  // [R1] alignment applied on presentation
  wire [15:0] aligned = align ? {result, 6'h00} : {6'h00, result};
  wire startBitRead = state != sac_pkg::ST_IDLE;
  wire [7:0] aRead = {enable, startBitRead, autoOn, flag, 1'b0, prescSel};
  wire [7:0] rdMux = hitA ? aRead :
                     hitB ? ctrlB :
                     hitM ? chRef :
                     hitL ? aligned[7:0] :
                     hitH ? aligned[15:8] :
                     hitX ? misc : 8'h00;

  // [R24] divisor is 2 shifted by the select code
  wire [15:0] divWide = 16'h0002 << prescSel;
  wire [7:0] divMinus1 = 8'(divWide - 16'h0001);
  wire [7:0] halfPoint = divMinus1 >> 1;
  wire adcRise = enable & (presc == divMinus1);
  wire adcFall = enable & (presc == halfPoint);
  wire halfTick = adcRise | adcFall;

  // [R9] own flag code means free running
  wire freeRun = autoOn & (tsel == sac_pkg::TSEL_OWN_FLAG);
  // [R23] trigger multiplexer over event sources
  wire selTrig = triggerSources[tsel];
  // [R7] only a rising edge counts, and never while converting
  // [R8] a source flag left high gives no new edge
  wire trigEdge = trigD1 & ~trigD2;
  wire trigStart = enable & autoOn & ~freeRun & trigEdge & (state != sac_pkg::ST_CONV);
  // [R10] start bit honoured with or without auto trigger
  wire wrStart = wrA & pwdata[sac_pkg::A_START] & pwdata[sac_pkg::A_ENABLE];
  // [R13] bit start waits for a converter clock rising edge
  wire bitStart = (state == sac_pkg::ST_ARMED) & adcRise & ~trigStart;

  // [R14] conversion lengths by kind
  wire [5:0] total = (kind == sac_pkg::KIND_FIRST) ? sac_pkg::HALF_FIRST_TOTAL :
                     (kind == sac_pkg::KIND_AUTO) ? sac_pkg::HALF_AUTO_TOTAL :
                     sac_pkg::HALF_NORMAL_TOTAL;
  // [R15] sample points by kind
  wire [5:0] shPoint = (kind == sac_pkg::KIND_FIRST) ? sac_pkg::HALF_FIRST_SH :
                       (kind == sac_pkg::KIND_AUTO) ? sac_pkg::HALF_AUTO_SH :
                       sac_pkg::HALF_NORMAL_SH;
  wire [5:0] halfNext = halfCount + 6'd1;
  wire converting = state == sac_pkg::ST_CONV;
  wire done = converting & halfTick & (halfNext == total);
  wire shNow = converting & halfTick & (halfNext == shPoint);
  // [R22] shadow tracks while enabled, except while a conversion holds it
  wire shadowTrack = enable & (~converting | (halfCount >= total - sac_pkg::HALF_LAST_CYCLE));
  wire [sac_pkg::CH_W-1:0] shCh = shadow.channel;

  sac_pkg::sac_kind_e startKind;
  assign startKind = firstPending ? sac_pkg::KIND_FIRST : sac_pkg::KIND_NORMAL;

  // bus slave: zero wait, answer prepared in setup
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      prdata <= setupPhase ? {24'h00_0000, rdMux} : 32'h0000_0000;
      pslverr <= setupPhase & ~mapped;
    end
  end

  // plain control registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrlA <= sac_pkg::RST_REG;
      ctrlB <= sac_pkg::RST_REG;
      chRef <= sac_pkg::RST_REG;
      misc <= sac_pkg::RST_REG;
    end else begin
      if (wrA) begin
        ctrlA <= {pwdata[7:6] & 2'b10, pwdata[5], 1'b0, 1'b0, pwdata[2:0]};
      end
      if (wrEn & hitB) begin
        ctrlB <= {5'h00, pwdata[2:0]};
      end
      if (wrEn & hitM) begin
        chRef <= pwdata[7:0];
      end
      if (wrEn & hitX) begin
        misc <= {5'h00, pwdata[2:0]};
      end
    end
  end

  // flag: set by completion wins over a write-one clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (done) begin
      // [R3] flag set whether or not the result is kept
      flag <= 1'b1;
    end else if (wrA & pwdata[sac_pkg::A_FLAG]) begin
      flag <= 1'b0;
    end
  end

  // [R2] low read locks, high read releases
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock <= 1'b0;
    end else if (rdEn & hitH) begin
      lock <= 1'b0;
    end else if (rdEn & hitL) begin
      lock <= 1'b1;
    end
  end

  // [R16] result written at completion unless locked
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result <= sac_pkg::RST_RESULT;
    end else if (done & ~lock) begin
      result <= coreResult;
    end
  end

  // [R11] prescaler held in reset while disabled
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      presc <= 8'h00;
    end else if (!enable || trigStart || adcRise) begin
      // [R6] trigger start restarts the prescaler
      presc <= 8'h00;
    end else begin
      presc <= presc + 8'h01;
    end
  end

  // trigger pipeline; the extra stage is the synchronisation delay
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trigD1 <= 1'b0;
      trigD2 <= 1'b0;
      enPrev <= 1'b0;
    end else begin
      trigD1 <= selTrig;
      trigD2 <= trigD1;
      enPrev <= enable;
    end
  end

  // first conversion after switch-on is the long one
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      firstPending <= 1'b0;
    end else if (enable & ~enPrev) begin
      firstPending <= 1'b1;
    end else if (done) begin
      firstPending <= 1'b0;
    end
  end

  // conversion sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= sac_pkg::ST_IDLE;
      kind <= sac_pkg::KIND_NORMAL;
      halfCount <= 6'd0;
    end else if (!enable) begin
      // a start written together with the enable must not be lost
      state <= wrStart ? sac_pkg::ST_ARMED : sac_pkg::ST_IDLE;
      halfCount <= 6'd0;
    end else if (trigStart) begin
      // [R6] auto start counts from the prescaler reset
      state <= sac_pkg::ST_CONV;
      kind <= firstPending ? sac_pkg::KIND_FIRST : sac_pkg::KIND_AUTO;
      halfCount <= 6'd0;
    end else if (done) begin
      // [R18] free running restarts at once, start stays high
      state <= freeRun ? sac_pkg::ST_CONV : sac_pkg::ST_IDLE;
      kind <= sac_pkg::KIND_NORMAL;
      halfCount <= 6'd0;
    end else if (bitStart) begin
      state <= sac_pkg::ST_CONV;
      kind <= startKind;
      halfCount <= 6'd0;
    end else if (converting & halfTick) begin
      halfCount <= halfNext;
    end else if ((state == sac_pkg::ST_IDLE) & wrStart) begin
      // [R4] start bit write arms a single conversion
      state <= sac_pkg::ST_ARMED;
    end
  end

  // [R5] frozen shadow keeps the old channel until the last converter cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shadow <= '0;
    end else if (shadowTrack) begin
      shadow <= '{reference: chRef[sac_pkg::M_REF_LO +: 2], extRef: misc[sac_pkg::X_EXTREF],
                  channel: chRef[sac_pkg::M_CH_LO +: sac_pkg::CH_W]};
    end
  end

  // [R20] channel decode; [R19] differential codes use the gain stage
  wire isDiff = shCh[sac_pkg::CH_DIFF_BIT];
  wire isTemp = shCh == sac_pkg::CH_TEMP;
  wire isIsrc = shCh == sac_pkg::CH_INTERNAL_CURRENT_SOURCE;

  // [R12] channel, reference and gain selections are blocked while disabled; refOut and isrcOn follow misc regardless
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      analogSel <= '0;
      sampleHold <= 1'b0;
      convBusy <= 1'b0;
      convDone <= 1'b0;
    end else begin
      analogSel.on <= enable;
      // [R21] reference field with external reference enable
      analogSel.reference <= enable ? shadow.reference : 2'b00;
      analogSel.extRef <= enable & shadow.extRef;
      analogSel.refOut <= misc[sac_pkg::X_REFOUT];
      analogSel.isrcOn <= misc[sac_pkg::X_INTERNAL_CURRENT_SOURCE];
      analogSel.channel <= enable ? shCh : 5'h00;
      analogSel.gainOn <= enable & isDiff;
      analogSel.gain20 <= enable & isDiff & shCh[sac_pkg::CH_GAIN20_BIT];
      analogSel.tempSel <= enable & isTemp;
      analogSel.isrcSel <= enable & isIsrc;
      // [R17] auto sample point two converter cycles after reset
      sampleHold <= shNow;
      convBusy <= converting & ~done;
      convDone <= done;
    end
  end

  // helper: single-ended code range check for the assertions
  wire singleCode = ~isDiff & (shCh <= sac_pkg::CH_LAST_SINGLE);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_lowRead;
    rdEn & hitL;
  endsequence
  sequence s_completes;
    done;
  endsequence

  a_flag_on_done: assert property (s_completes |=> flag) // [R3]
    else $error("completion did not set the flag");
  a_lock_blocks: assert property (done & lock |=> $stable(result)) // [R2]
    else $error("locked result was overwritten");
  a_lock_sets: assert property (s_lowRead |=> lock) // [R2]
    else $error("low result read did not lock the results");
  a_single_clears: assert property (done & ~freeRun & ~trigStart |=> state == sac_pkg::ST_IDLE) // [R16]
    else $error("start bit not cleared at completion");
  a_free_stays: assert property (done & freeRun |=> state == sac_pkg::ST_CONV && halfCount == 6'd0) // [R18]
    else $error("free running did not restart");
  a_presc_held: assert property (!enable |=> presc == 8'h00) // [R11]
    else $error("prescaler ran while disabled");
  a_edge_ignored: assert property (converting & trigEdge & ~done |=> converting) // [R7]
    else $error("trigger edge disturbed a conversion");
  a_shadow_frozen: assert property (converting & ~shadowTrack |=> $stable(shadow)) // [R22]
    else $error("shadow moved during sampling");
  a_armed_waits: assert property (state == sac_pkg::ST_ARMED & ~adcRise & ~trigStart & enable |=>
                                  state == sac_pkg::ST_ARMED) // [R13]
    else $error("conversion began off a converter edge");
  a_auto_sample: assert property (trigStart ##1 (converting & ~shNow)[*1] |-> kind != sac_pkg::KIND_NORMAL) // [R17]
    else $error("auto start used the wrong timing");
  a_gain_bypass: assert property (enable & singleCode |=> ~analogSel.gainOn) // [R19]
    else $error("gain stage used for single ended input");
  a_disabled_quiet: assert property (!enable |=> analogSel.channel == 5'h00 && !analogSel.on) // [R12]
    else $error("selection applied while disabled");
endmodule
`default_nettype wire

// file: sac_core_model.sv
// converter core model: samples a channel-derived code, scrambles the bus when idle
`timescale 1ns/10ps
`default_nettype none
module sac_core_model (
  input wire logic clock,
  input wire logic rstn,
  input wire sac_pkg::sac_analog_s analogSel,
  input wire logic sampleHold,
  input wire logic convDone,
  output logic [9:0] coreResult
);
  logic [9:0] held;
  logic [9:0] junk;
  logic valid;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      held <= 10'h000;
      junk <= 10'h000;
      valid <= 1'b0;
    end else begin
      junk <= junk + 10'h135;
      if (sampleHold) begin
        held <= {analogSel.channel, ~analogSel.channel};
        valid <= 1'b1;
      end else if (convDone) begin
        valid <= 1'b0;
      end
    end
  end
  // no stale value outside a conversion, so a late sample shows up
  assign coreResult = valid ? held : junk;
endmodule
`default_nettype wire

// file: sac_conversion_control_tb.sv
// testbench: register-driven checks of conversion control timing and results
`timescale 1ns/10ps
`default_nettype none
module sac_conversion_control_tb;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, sampleHold, convBusy, convDone;
  logic [7:0] paddr, triggerSources;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] coreResult;
  sac_pkg::sac_analog_s analogSel;
  int n_fail, compares, len, busyRun;
  logic lastErr;
  sac_conversion_control dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .triggerSources(triggerSources), .coreResult(coreResult), .analogSel(analogSel),
    .sampleHold(sampleHold), .convBusy(convBusy), .convDone(convDone));
  sac_core_model core (.clock(clock), .rstn(rstn), .analogSel(analogSel), .sampleHold(sampleHold),
    .convDone(convDone), .coreResult(coreResult));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // length of the current busy run, read by wait_done at the completion pulse
  always @(posedge clock) begin
    busyRun <= (convBusy === 1'b1) ? busyRun + 1 : 0;
  end
  task stop_test();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    if (n == 50) n_fail++;
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  // conversion length in clocks; busy shows one clock after the start edge
  task wait_done(output int n);
    int g;
    g = 0;
    while (convDone !== 1'b1 && g < 400) begin
      @(posedge clock);
      g++;
    end
    if (g == 400) n_fail++;
    n = busyRun + 1;
  endtask
  task rd_res(input logic left, input logic [9:0] exp);
    logic [31:0] lo, hi;
    apb(1'b0, sac_pkg::OFS_RES_LOW, 8'h00, lo);
    apb(1'b0, sac_pkg::OFS_RES_HIGH, 8'h00, hi);
    if (left) chk({hi[7:0], lo[7:6]}, {22'h0, exp});
    else chk({hi[1:0], lo[7:0]}, {22'h0, exp});
  endtask
  task t_reset();
    logic [31:0] r;
    apb(1'b0, sac_pkg::OFS_CTRL_A, 8'h00, r);
    chk(r, 32'h00000000);
    apb(1'b0, 8'h40, 8'h00, r);
    chk({31'h0, lastErr}, 32'h00000001);
    wr(sac_pkg::OFS_CHREF, 8'h03);
    // no selection reaches the core while disabled
    chk({31'h0, analogSel.on}, 32'h0);
    chk({27'h0, analogSel.channel}, 32'h0);
    $display("test reset done");
  endtask
  task t_first_normal();
    wr(sac_pkg::OFS_CTRL_A, 8'hc0);
    repeat (4) @(posedge clock);
    chk({31'h0, analogSel.on}, 32'h1);
    apb(1'b0, sac_pkg::OFS_CTRL_A, 8'h00, rd);
    chk({31'h0, rd[6]}, 32'h1);
    // channel change in mid-conversion must not affect this result
    wr(sac_pkg::OFS_CHREF, 8'h1f);
    wait_done(len);
    chk(len, 50);
    @(posedge clock);
    apb(1'b0, sac_pkg::OFS_CTRL_A, 8'h00, rd);
    chk({28'h0, rd[7:4]}, 32'h9);
    rd_res(1'b0, 10'h07c);
    wr(sac_pkg::OFS_CTRL_A, 8'hd0);
    wait_done(len);
    chk(len, 26);
    wr(sac_pkg::OFS_CHREF, 8'h3f);
    rd_res(1'b1, 10'h3e0);
    chk({30'h0, analogSel.gainOn, analogSel.gain20}, 32'h3);
    $display("test first and normal done");
  endtask
  task t_lock();
    wr(sac_pkg::OFS_CHREF, 8'hc3);
    apb(1'b0, sac_pkg::OFS_RES_LOW, 8'h00, rd);
    chk({30'h0, analogSel.reference}, 32'h3);
    wr(sac_pkg::OFS_CTRL_A, 8'hd0);
    wait_done(len);
    @(posedge clock);
    apb(1'b0, sac_pkg::OFS_CTRL_A, 8'h00, rd);
    chk({31'h0, rd[4]}, 32'h1);
    apb(1'b0, sac_pkg::OFS_RES_HIGH, 8'h00, rd);
    // high still from the locked left-over result
    chk(rd, 32'h00000003);
    wr(sac_pkg::OFS_CTRL_A, 8'hd0);
    wait_done(len);
    @(posedge clock);
    rd_res(1'b0, 10'h07c);
    $display("test lock done");
  endtask
  task t_auto();
    wr(sac_pkg::OFS_CTRL_B, 8'h01);
    wr(sac_pkg::OFS_CTRL_A, 8'hb0);
    triggerSources <= 8'h02;
    len = 0;
    while (convBusy !== 1'b1 && len < 40) begin
      @(posedge clock);
      len++;
    end
    chk({31'h0, convBusy}, 32'h1);
    // source flag cleared before its next event
    triggerSources <= 8'h00;
    repeat (4) @(posedge clock);
    triggerSources <= 8'h02;
    wait_done(len);
    chk(len, 27);
    repeat (80) @(posedge clock);
    // level held high and mid-conversion edge start nothing
    chk({31'h0, convBusy}, 32'h0);
    triggerSources <= 8'h00;
    wr(sac_pkg::OFS_CTRL_A, 8'hf0);
    apb(1'b0, sac_pkg::OFS_CTRL_A, 8'h00, rd);
    chk({31'h0, rd[6]}, 32'h1);
    wait_done(len);
    $display("test auto done");
  endtask
  task t_free();
    wr(sac_pkg::OFS_CTRL_B, 8'h00);
    wr(sac_pkg::OFS_CTRL_A, 8'he0);
    wait_done(len);
    @(posedge clock);
    // next conversion follows without a flag clear
    wait_done(len);
    chk(len, 26);
    @(posedge clock);
    apb(1'b0, sac_pkg::OFS_CTRL_A, 8'h00, rd);
    chk({31'h0, rd[6]}, 32'h1);
    wr(sac_pkg::OFS_CTRL_A, 8'h00);
    repeat (3) @(posedge clock);
    chk({31'h0, convBusy}, 32'h0);
    $display("test free running done");
  endtask
  initial begin
    n_fail = 0;
    compares = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    triggerSources = 8'h00;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_first_normal();
    t_lock();
    t_auto();
    t_free();
    stop_test();
  end
  initial begin
    #(40 * 20000);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
